// file: common/hrx_pkg.sv
/* Constants and carriers for one serial channel's receive and DMA path.
   Assumes a single clock domain and a synchronous frame byte source. */
package hrx_pkg;
   localparam int HRX_DEPTH = 64;
   localparam int HRX_HALF = 32;
   localparam logic [6:0] HRX_THR_RESET = 7'h20;
   localparam logic [6:0] HRX_HDLC_MIN = 7'h02;
   localparam logic [6:0] HRX_ASYNC_MIN = 7'h01;
   localparam logic [7:0] HRX_GROUP_A = 8'hFE;
   localparam logic [7:0] HRX_GROUP_B = 8'hFC;
   localparam logic [7:0] HRX_CR_MASK = 8'hFD;
   localparam int HRX_CR_BIT = 1;
   localparam logic [7:0] HRX_FIFO_ADDR = 8'h00;
   localparam logic [1:0] HRX_MODE_AUTO = 2'h0;
   localparam logic [1:0] HRX_MODE_TRANSP = 2'h2;
   localparam logic [1:0] HRX_MODE_EXT = 2'h3;
   localparam int HRX_ST_CRC_OK = 7;
   localparam int HRX_ST_ABORT = 6;
   localparam int HRX_ST_CR = 5;
   localparam int HRX_ST_AUTO = 4;
   localparam int HRX_ST_HI2 = 3;
   localparam int HRX_ST_LO2 = 2;
   typedef struct packed {
      logic [7:0] data;
      logic last;
      logic crc_ok;
      logic abort;
   } hrx_item_t;
   typedef struct packed {
      logic [7:0] high_compare_one;
      logic [7:0] high_compare_two;
      logic [7:0] low_compare_one;
      logic [7:0] low_compare_two;
      logic cmd_resp_handling_bit;
   } hrx_addr_cfg_t;
   typedef enum {HRX_S_RUN, HRX_S_SKIP, HRX_S_STAT} hrx_state_t;
endpackage

// file: verilog/hrx_channel.sv
/* One serial channel: frame filtering, receive and transmit queues with DMA requests.
   Assumes bus strobes and frame bytes synchronous to i_clk, one clock for all. */
`timescale 1ns/10ps
module hrx_channel #(
   parameter int DEPTH = hrx_pkg::HRX_DEPTH,
   parameter int HALF = hrx_pkg::HRX_HALF
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_mode_select_hi,
   input wire logic i_mode_select_lo,
   input wire logic i_address_mode_bit,
   input wire logic i_proto_hdlc,
   input wire logic i_first_silicon,
   input wire logic i_dma_invert,
   input wire logic i_split_strobe,
   input wire logic i_bus_wide,
   input wire logic i_thr_load,
   input wire logic [5:0] i_rx_threshold,
   input wire hrx_pkg::hrx_addr_cfg_t i_addr_cfg,
   input wire logic i_item_valid,
   input wire hrx_pkg::hrx_item_t i_item,
   output logic o_rx_ready,
   input wire logic i_rx_bit,
   input wire logic i_rx_bit_valid,
   input wire logic i_dma_acknowledge_b,
   input wire logic i_cs_b,
   input wire logic [7:0] i_addr,
   input wire logic i_rd_b,
   input wire logic i_wr_b,
   input wire logic i_bhe_b,
   input wire logic [15:0] i_data,
   output logic [15:0] o_data,
   output logic o_data_oe,
   output logic o_rx_dma_request,
   output logic o_tx_dma_request,
   output logic o_tx_valid,
   output logic [7:0] o_tx_byte,
   input wire logic i_tx_ready,
   output logic [7:0] o_rx_control_field_reg,
   output logic [7:0] o_rx_frame_status_reg,
   output logic [7:0] o_low_compare_one
);
   import hrx_pkg::*;
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] HALF_C = CW'(HALF);
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [CW-1:0] ONE_C = CW'(1);
   localparam logic [CW-1:0] TWO_C = CW'(2);

   ////////////////////////////////////////////////////////////////////////////////
   // Bus strobes
   logic rd_q, wr_q;
   wire dma_acknowledge = !i_dma_acknowledge_b;
   wire inv = i_dma_invert && dma_acknowledge;
   wire rw = i_wr_b ^ inv;
   wire rd_act = i_split_strobe ? (inv ? !i_wr_b : !i_rd_b) : (!i_rd_b && rw);
   wire wr_act = i_split_strobe ? (inv ? !i_rd_b : !i_wr_b) : (!i_rd_b && !rw);
   wire sel = dma_acknowledge || (!i_cs_b && i_addr == HRX_FIFO_ADDR);
   wire rd_start = rd_act && !rd_q && sel;
   wire wr_start = wr_act && !wr_q && sel;
   wire word = i_bus_wide && !i_bhe_b;

   ////////////////////////////////////////////////////////////////////////////////
   // Receive threshold
   logic [CW-1:0] thr;
   wire [CW-1:0] thr_floor = i_proto_hdlc ? CW'(HRX_HDLC_MIN) : CW'(HRX_ASYNC_MIN);
   wire [CW-1:0] thr_clip = (thr > HALF_C) ? HALF_C : thr;
   wire [CW-1:0] thr_eff = (i_proto_hdlc && i_first_silicon) ? HALF_C :
                           (thr_clip < thr_floor) ? thr_floor : thr_clip;

   ////////////////////////////////////////////////////////////////////////////////
   // Two-entry input buffer
   logic [1:0] sk_cnt;
   hrx_item_t sk_buf [2];
   logic [7:0] sh, ext_b;
   logic [2:0] bcnt;
   logic ext_v;
   logic take;
   wire [1:0] mode = {i_mode_select_hi, i_mode_select_lo};
   wire address_mode_bit = i_address_mode_bit;
   wire ext_mode = mode == HRX_MODE_EXT;
   wire sk_in_valid = ext_mode ? (ext_v && address_mode_bit) : i_item_valid;
   wire hrx_item_t sk_in = ext_mode ? hrx_item_t'({ext_b, 3'b000}) : i_item;
   wire sk_push = sk_in_valid && o_rx_ready;
   wire sk_valid = sk_cnt != 2'd0;
   wire hrx_item_t sk_out = sk_buf[0];
   wire [1:0] next_sk_cnt = sk_cnt + 2'(sk_push) - 2'(take);

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sk_cnt <= 2'd0;
         o_rx_ready <= 1'b1;
      end else begin
         sk_cnt <= next_sk_cnt;
         o_rx_ready <= next_sk_cnt != 2'd2;
      end
   end

   always_ff @(posedge i_clk) begin
      if (take) begin
         sk_buf[0] <= (sk_cnt == 2'd2) ? sk_buf[1] : sk_in;
      end else if (sk_push && sk_cnt == 2'd0) begin
         sk_buf[0] <= sk_in;
      end
      if (sk_push && (sk_cnt == 2'd1) != take) begin
         sk_buf[1] <= sk_in;
      end
   end

   // Raw bit assembly, LSB first, for the extended transparent mode
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sh <= 8'h00;
         bcnt <= 3'd0;
         ext_v <= 1'b0;
         ext_b <= 8'h00;
      end else begin
         ext_v <= ext_mode && i_rx_bit_valid && bcnt == 3'd7;
         if (ext_mode && i_rx_bit_valid) begin
            sh <= {i_rx_bit, sh[7:1]};
            bcnt <= bcnt + 3'd1;
            if (bcnt == 3'd7) begin
               ext_b <= {i_rx_bit, sh[7:1]};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Frame filtering
   hrx_state_t state, next_state;
   logic [1:0] idx;
   logic hi1_q, hi2_q, lo2_q, cr_q, auto_q, crc_q, abt_q;
   logic [CW-1:0] rq_cnt;
   logic [7:0] stat_byte;
   wire hd_mode = !i_mode_select_hi;
   wire tr1 = mode == HRX_MODE_TRANSP && address_mode_bit;
   wire tr0 = mode == HRX_MODE_TRANSP && !address_mode_bit;
   wire [7:0] b = sk_out.data;
   wire [7:0] hmask = i_addr_cfg.cmd_resp_handling_bit ? HRX_CR_MASK : '1;
   wire [7:0] bm = b & hmask;
   wire hm1 = bm == (i_addr_cfg.high_compare_one & hmask);
   wire hm2 = bm == (i_addr_cfg.high_compare_two & hmask);
   wire hmg = bm == (HRX_GROUP_A & hmask) || bm == (HRX_GROUP_B & hmask);
   wire lm1 = b == i_addr_cfg.low_compare_one;
   wire lm2 = b == i_addr_cfg.low_compare_two;
   wire is_hi = idx == 2'd0 && ((hd_mode && address_mode_bit) || tr1);
   wire is_lo = hd_mode && idx == (address_mode_bit ? 2'd1 : 2'd0);
   wire is_ctl = (hd_mode && idx == (address_mode_bit ? 2'd2 : 2'd1)) || (tr1 && idx == 2'd2) ||
                 (tr0 && idx == 2'd1);
   wire to_low_compare_one = (tr1 && idx == 2'd1) || (tr0 && idx == 2'd0);
   wire drop = state == HRX_S_SKIP || (is_hi && !(hm1 || hm2 || hmg)) ||
               (is_lo && !(lm1 || lm2));
   wire auto_now = mode == HRX_MODE_AUTO && lm1 && (hi1_q || !address_mode_bit);
   wire room = rq_cnt < DEPTH_C - ONE_C;
   assign take = sk_valid && state != HRX_S_STAT && room;
   wire keep = take && !drop && !is_hi && !is_lo;
   wire rq_push = keep || state == HRX_S_STAT;
   wire [8:0] rq_din = (state == HRX_S_STAT) ? {1'b1, stat_byte} : {1'b0, b};

   always_comb begin
      stat_byte = 8'h00;
      stat_byte[HRX_ST_CRC_OK] = crc_q;
      stat_byte[HRX_ST_ABORT] = abt_q;
      stat_byte[HRX_ST_CR] = cr_q;
      stat_byte[HRX_ST_AUTO] = auto_q;
      stat_byte[HRX_ST_HI2] = hi2_q;
      stat_byte[HRX_ST_LO2] = lo2_q;
   end

   always_comb begin
      next_state = state;
      case (state)
         HRX_S_RUN: begin
            if (take && sk_out.last) begin
               next_state = drop ? HRX_S_RUN : HRX_S_STAT;
            end else if (take && drop) begin
               next_state = HRX_S_SKIP;
            end
         end
         HRX_S_SKIP: begin
            if (take && sk_out.last) begin
               next_state = HRX_S_RUN;
            end
         end
         HRX_S_STAT: next_state = HRX_S_RUN;
         default: next_state = HRX_S_RUN;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state <= HRX_S_RUN;
         idx <= 2'd0;
         {hi1_q, hi2_q, lo2_q, cr_q, auto_q, crc_q, abt_q} <= 7'h00;
      end else begin
         state <= next_state;
         if (take) begin
            idx <= sk_out.last ? 2'd0 : (idx == 2'd3 ? idx : idx + 2'd1);
            if (idx == 2'd0) begin
               {hi1_q, hi2_q, lo2_q, cr_q, auto_q} <= 5'h00;
            end
            if (is_hi) begin
               hi1_q <= hm1;
               hi2_q <= hm2;
               cr_q <= b[HRX_CR_BIT];
            end
            if (is_lo) begin
               lo2_q <= lm2;
               auto_q <= auto_now;
               if (!address_mode_bit) begin
                  cr_q <= lm2;
               end
            end
            if (sk_out.last) begin
               crc_q <= sk_out.crc_ok;
               abt_q <= sk_out.abort;
            end
         end
      end
   end

   // Hardware-loaded field registers, and the threshold loaded on i_thr_load
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rx_control_field_reg <= 8'h00;
         o_rx_frame_status_reg <= 8'h00;
         o_low_compare_one <= 8'h00;
         thr <= CW'(HRX_THR_RESET);
      end else begin
         if (i_thr_load) begin
            thr <= CW'(i_rx_threshold);
         end
         if (take && is_ctl && !drop) begin
            o_rx_control_field_reg <= b;
         end
         if (state == HRX_S_STAT) begin
            o_rx_frame_status_reg <= stat_byte;
         end
         if (ext_mode) begin
            o_low_compare_one <= ext_v ? ext_b : o_low_compare_one;
         end else if (take && to_low_compare_one && !drop) begin
            o_low_compare_one <= b;
         end else if (hd_mode) begin
            o_low_compare_one <= i_addr_cfg.low_compare_one;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Receive queue and request
   logic [8:0] rq_mem [DEPTH];
   logic [AW-1:0] rq_w, rq_r;
   logic [CW-1:0] rq_ends, rx_left;
   wire [AW-1:0] rq_r1 = rq_r + AW'(1);
   wire [CW-1:0] half_room = HALF_C - CW'(rq_r[AW-2:0]);
   wire rx_avail = rq_cnt >= thr_eff || (rq_ends != '0 && rq_cnt != '0);
   wire [CW-1:0] blk_a = (thr_eff < rq_cnt) ? thr_eff : rq_cnt;
   wire [CW-1:0] rx_blk = (blk_a < half_room) ? blk_a : half_room;
   wire rx_pop = rd_start && rx_left != '0;
   wire rx_two = rx_pop && word && rx_left >= TWO_C;
   wire [CW-1:0] rx_step = rx_two ? TWO_C : ONE_C;
   wire [CW-1:0] next_rx_left = rx_pop ? rx_left - rx_step :
                                (rx_left == '0 && rx_avail) ? rx_blk : rx_left;
   wire [CW-1:0] ends_dec = CW'(rx_pop && rq_mem[rq_r][8]) + CW'(rx_two && rq_mem[rq_r1][8]);

   always_ff @(posedge i_clk) begin
      if (rq_push) begin
         rq_mem[rq_w] <= rq_din;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         {rq_w, rq_r} <= '0;
         {rq_cnt, rq_ends, rx_left} <= '0;
         {rd_q, wr_q, o_data_oe, o_rx_dma_request} <= 4'h0;
         o_data <= 16'h0000;
      end else begin
         rd_q <= rd_act;
         wr_q <= wr_act;
         o_data_oe <= rd_act && sel;
         rq_w <= rq_w + AW'(rq_push);
         rq_r <= rq_r + AW'(rx_pop ? rx_step : '0);
         rq_cnt <= rq_cnt + CW'(rq_push) - (rx_pop ? rx_step : '0);
         rq_ends <= rq_ends + CW'(rq_push && rq_din[8]) - ends_dec;
         rx_left <= next_rx_left;
         o_rx_dma_request <= next_rx_left != '0;
         if (rd_start) begin
            o_data <= rx_pop ? {rx_two ? rq_mem[rq_r1][7:0] : 8'h00, rq_mem[rq_r][7:0]} : '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transmit queue and request
   logic [7:0] tq_mem [DEPTH];
   logic [AW-1:0] tq_w, tq_r;
   logic [CW-1:0] tq_cnt, tx_left;
   wire tx_push = wr_start && tx_left != '0;
   wire tx_two = tx_push && word && tx_left >= TWO_C;
   wire [CW-1:0] tx_step = tx_two ? TWO_C : ONE_C;
   wire tx_pop = tq_cnt != '0 && (!o_tx_valid || i_tx_ready);
   wire [CW-1:0] next_tx_left = tx_push ? tx_left - tx_step :
                                (tx_left == '0 && DEPTH_C - tq_cnt >= HALF_C) ? HALF_C : tx_left;

   always_ff @(posedge i_clk) begin
      if (tx_push) begin
         tq_mem[tq_w] <= i_data[7:0];
      end
      if (tx_two) begin
         tq_mem[tq_w + AW'(1)] <= i_data[15:8];
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         {tq_w, tq_r} <= '0;
         {tq_cnt, tx_left} <= '0;
         o_tx_dma_request <= 1'b0;
         o_tx_valid <= 1'b0;
         o_tx_byte <= 8'h00;
      end else begin
         tq_w <= tq_w + AW'(tx_push ? tx_step : '0);
         tq_r <= tq_r + AW'(tx_pop);
         tq_cnt <= tq_cnt + (tx_push ? tx_step : '0) - CW'(tx_pop);
         tx_left <= next_tx_left;
         o_tx_dma_request <= next_tx_left != '0;
         if (tx_pop) begin
            o_tx_valid <= 1'b1;
            o_tx_byte <= tq_mem[tq_r];
         end else if (i_tx_ready) begin
            o_tx_valid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_rx_req_drop;
      @(posedge i_clk) disable iff (!i_rst_b)
      (rx_pop && rx_left == rx_step) |=> !o_rx_dma_request;
   endproperty
   a_rx_req_drop: assert property (p_rx_req_drop)
      else $error("rx request held after last cycle");

   property p_rx_req_level;
      @(posedge i_clk) disable iff (!i_rst_b)
      (rx_left != '0 && !rx_pop) |=> o_rx_dma_request && $stable(rx_left);
   endproperty
   a_rx_req_level: assert property (p_rx_req_level)
      else $error("rx request dropped early");

   property p_dma_acknowledge_top;
      @(posedge i_clk) disable iff (!i_rst_b)
      (dma_acknowledge && i_cs_b && rd_act && !rd_q && rx_left != '0) |=> rq_r != $past(rq_r);
   endproperty
   a_dma_acknowledge_top: assert property (p_dma_acknowledge_top)
      else $error("acknowledged read did not pop");

   property p_inv_swap;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_split_strobe && dma_acknowledge && i_dma_invert && !i_wr_b && i_rd_b && !rd_q &&
       rx_left != '0) |=> rq_r != $past(rq_r);
   endproperty
   a_inv_swap: assert property (p_inv_swap)
      else $error("inverted strobe not taken as read");

   property p_thr_range;
      @(posedge i_clk) disable iff (!i_rst_b)
      thr_eff >= thr_floor && thr_eff <= HALF_C;
   endproperty
   a_thr_range: assert property (p_thr_range)
      else $error("threshold out of range");

   property p_v1_thr;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_proto_hdlc && i_first_silicon && rq_cnt < HALF_C && rq_ends == '0 &&
       rx_left == '0) |=> !o_rx_dma_request;
   endproperty
   a_v1_thr: assert property (p_v1_thr)
      else $error("request below 32 bytes");

   property p_half;
      @(posedge i_clk) disable iff (!i_rst_b)
      rx_left <= half_room;
   endproperty
   a_half: assert property (p_half)
      else $error("block crosses half");

   property p_discard;
      @(posedge i_clk) disable iff (!i_rst_b)
      (state == HRX_S_SKIP) |-> !rq_push;
   endproperty
   a_discard: assert property (p_discard)
      else $error("discarded frame stored");

   property p_status;
      @(posedge i_clk) disable iff (!i_rst_b)
      (keep && sk_out.last) |=> rq_push && rq_din[8];
   endproperty
   a_status: assert property (p_status)
      else $error("status byte missing");

   property p_group;
      @(posedge i_clk) disable iff (!i_rst_b)
      (take && is_hi && bm == (HRX_GROUP_A & hmask)) |=> state != HRX_S_SKIP;
   endproperty
   a_group: assert property (p_group)
      else $error("group address rejected");

   property p_ext_ral;
      @(posedge i_clk) disable iff (!i_rst_b)
      (ext_v && ext_mode) |=> o_low_compare_one == $past(ext_b);
   endproperty
   a_ext_ral: assert property (p_ext_ral)
      else $error("assembled byte not shown");
endmodule

// file: dv/hrx_dma_model.sv
/* Demand-mode DMA controller facing one channel, acknowledged or addressed cycles.
   Assumes split read/write strobes and byte accesses on the low lane. */
`timescale 1ns/10ps
module hrx_dma_model (
   input wire logic i_clk,
   input wire logic i_rx_dma_request,
   input wire logic i_tx_dma_request,
   input wire logic i_tx_en,
   input wire logic i_invert,
   input wire logic i_use_addr,
   input wire logic [15:0] i_data,
   output logic o_dma_acknowledge_b,
   output logic o_cs_b,
   output logic [7:0] o_addr,
   output logic o_rd_b,
   output logic o_wr_b,
   output logic [15:0] o_data,
   output logic [7:0] o_got,
   output logic o_got_valid
);
   logic [7:0] wr_cnt;
   logic more;
   initial begin
      more = 1'b0;
      o_cs_b = 1'b1;
      o_addr = 8'hFF;
      o_dma_acknowledge_b = 1'b1;
      o_rd_b = 1'b1;
      o_wr_b = 1'b1;
      o_data = 16'h0000;
      o_got = 8'h00;
      o_got_valid = 1'b0;
      wr_cnt = 8'h00;
   end
   // One acknowledged or addressed cycle; strobe held for two clocks
   task automatic cyc(input logic wr);
      @(posedge i_clk);
      o_dma_acknowledge_b <= i_use_addr;
      o_cs_b <= !i_use_addr;
      o_addr <= i_use_addr ? hrx_pkg::HRX_FIFO_ADDR : 8'hFF;
      o_rd_b <= wr ^ i_invert;
      o_wr_b <= !wr ^ i_invert;
      o_data <= {8'h00, 8'h40 + wr_cnt};
      @(posedge i_clk);
      @(negedge i_clk);
      o_got = i_data[7:0];
      o_got_valid = !wr;
      more = wr ? i_tx_dma_request : i_rx_dma_request;
      @(posedge i_clk);
      o_dma_acknowledge_b <= 1'b1;
      o_cs_b <= 1'b1;
      o_addr <= 8'hFF;
      o_rd_b <= 1'b1;
      o_wr_b <= 1'b1;
      o_data <= ~o_data;
      o_got_valid <= 1'b0;
      if (wr) wr_cnt <= wr_cnt + 8'h01;
      @(negedge i_clk);
   endtask
   ////////////////////////////////////////////////////////////////
   // Serves one whole block: stops once the request is seen low after a cycle starts
   always begin
      @(negedge i_clk);
      more = 1'b1;
      if (i_rx_dma_request) begin
         while (more) cyc(1'b0);
      end else if (i_tx_dma_request && i_tx_en) begin
         while (more) cyc(1'b1);
      end
   end
endmodule

// file: dv/tb_hrx_channel.sv
/* Self-checking bench: transmit blocks, address filtering, raw bits.
   Assumes the DMA model and the design package. */
`timescale 1ns/10ps
module tb_hrx_channel;
   import hrx_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic hi = 1'b0;
   logic lo = 1'b0;
   logic address_mode_bit = 1'b0;
   logic hdlc = 1'b1;
   logic thr_ld = 1'b0;
   logic [5:0] thr = 6'h20;
   hrx_addr_cfg_t cfg = '{8'hF0, 8'hF4, 8'h31, 8'h32, 1'b0};
   logic iv = 1'b0;
   hrx_item_t item = '0;
   logic bit_v = 1'b0;
   logic rbit = 1'b0;
   logic tx_en = 1'b0;
   logic tx_rdy = 1'b0;
   logic fsil = 1'b0;
   logic dinv = 1'b0;
   logic uadr = 1'b0;
   logic rdy, ack_b, rd_b, wr_b, rq_r, rq_t, tv, gv, cs_b, oe;
   logic [15:0] dw, dr;
   logic [7:0] tbyte, ctl, sta, lc1, got, addr;
   logic [7:0] auto_exp [4] = '{8'h11, 8'hA5, 8'h5A, 8'h90};
   int error_cnt = 0;
   int total_checks = 0;
   int tx_seen = 0;
   logic [7:0] q[$];
   always #2 clk = ~clk;
   hrx_channel uut (.i_clk(clk), .i_rst_b(rst_b), .i_mode_select_hi(hi),
      .i_mode_select_lo(lo), .i_address_mode_bit(address_mode_bit), .i_proto_hdlc(hdlc),
      .i_first_silicon(fsil), .i_dma_invert(dinv), .i_split_strobe(1'b1),
      .i_bus_wide(1'b0), .i_thr_load(thr_ld), .i_rx_threshold(thr), .i_addr_cfg(cfg),
      .i_item_valid(iv), .i_item(item), .o_rx_ready(rdy), .i_rx_bit(rbit),
      .i_rx_bit_valid(bit_v), .i_dma_acknowledge_b(ack_b), .i_cs_b(cs_b),
      .i_addr(addr), .i_rd_b(rd_b), .i_wr_b(wr_b), .i_bhe_b(1'b1), .i_data(dw),
      .o_data(dr), .o_data_oe(oe), .o_rx_dma_request(rq_r), .o_tx_dma_request(rq_t),
      .o_tx_valid(tv), .o_tx_byte(tbyte), .i_tx_ready(tx_rdy),
      .o_rx_control_field_reg(ctl), .o_rx_frame_status_reg(sta),
      .o_low_compare_one(lc1));
   hrx_dma_model dma (.i_clk(clk), .i_rx_dma_request(rq_r), .i_tx_dma_request(rq_t),
      .i_tx_en(tx_en), .i_invert(dinv), .i_use_addr(uadr), .i_data(dr),
      .o_dma_acknowledge_b(ack_b), .o_cs_b(cs_b), .o_addr(addr), .o_rd_b(rd_b),
      .o_wr_b(wr_b), .o_data(dw), .o_got(got), .o_got_valid(gv));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      if (error_cnt == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (gv) begin
         q.push_back(got);
         check(8'(oe), 8'h01);
      end
   end
   always @(posedge clk) tx_rdy <= ~tx_rdy;
   always @(negedge clk) begin
      if (tv && tx_rdy) begin
         check(tbyte, 8'h40 + tx_seen[7:0]);
         tx_seen++;
      end
   end
   task automatic put(input logic [7:0] b, input logic last);
      @(posedge clk);
      iv <= 1'b1;
      item <= '{data: b, last: last, crc_ok: 1'b1, abort: 1'b0};
      @(negedge clk);
      while (!rdy) @(negedge clk);
      @(posedge clk);
      iv <= 1'b0;
   endtask
   // Frame of address, second byte c and data A5 5A, then drained by DMA
   task automatic frame(input logic [1:0] md, input logic [7:0] a, input logic [7:0] c);
      q.delete();
      @(posedge clk);
      {hi, lo} <= md;
      put(a, 1'b0);
      put(c, 1'b0);
      put(8'hA5, 1'b0);
      put(8'h5A, 1'b1);
      repeat (90) @(negedge clk);
   endtask
   task automatic rx_byte(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         rbit <= v[i];
         bit_v <= 1'b1;
      end
      @(posedge clk);
      bit_v <= 1'b0;
      repeat (60) @(negedge clk);
   endtask
   initial begin
      #80000;
      error_cnt++;
      final_report();
   end
   initial begin
      repeat (20) @(negedge clk);
      check(rdy, 1'b1);
      check(rq_t, 1'b0);
      @(posedge clk);
      rst_b <= 1'b1;
      tx_en <= 1'b1;
      for (int i = 0; i < 3000 && tx_seen < HRX_HALF + 8; i++) @(negedge clk);
      @(posedge clk);
      tx_en <= 1'b0;
      repeat (200) @(negedge clk);
      check(8'(tx_seen % HRX_HALF), 8'h00);
      check(rq_r, 1'b0);
      frame(2'h0, 8'h31, 8'h11);
      check(8'(q.size()), 8'h04);
      foreach (q[i]) check(q[i], auto_exp[i[1:0]]);
      check(ctl, 8'h11);
      check(sta, 8'h90);
      @(posedge clk);
      dinv <= 1'b1;
      frame(2'h1, 8'h32, 8'h11);
      check(8'(q.size()), 8'h04);
      check(q[3], 8'hA4);
      check(q[0], 8'h11);
      @(posedge clk);
      dinv <= 1'b0;
      frame(2'h1, 8'h77, 8'h11);
      check(8'(q.size()), 8'h00);
      @(posedge clk);
      address_mode_bit <= 1'b1;
      uadr <= 1'b1;
      cfg.low_compare_two <= 8'h11;
      frame(2'h1, 8'hFE, 8'h11);
      check(8'(q.size()), 8'h03);
      check(q[2], 8'hA4);
      @(posedge clk);
      address_mode_bit <= 1'b0;
      uadr <= 1'b0;
      frame(2'h2, 8'h77, 8'h22);
      check(lc1, 8'h77);
      check(ctl, 8'h22);
      q.delete();
      @(posedge clk);
      fsil <= 1'b1;
      thr <= 6'h02;
      thr_ld <= 1'b1;
      @(posedge clk);
      thr_ld <= 1'b0;
      put(8'h01, 1'b0);
      put(8'h02, 1'b0);
      repeat (30) @(negedge clk);
      check(rq_r, 1'b0);
      @(posedge clk);
      fsil <= 1'b0;
      repeat (30) @(negedge clk);
      check(8'(q.size()), 8'h02);
      put(8'h03, 1'b1);
      repeat (30) @(negedge clk);
      @(posedge clk);
      {hi, lo} <= 2'h3;
      rx_byte(8'hC6);
      check(lc1, 8'hC6);
      q.delete();
      @(posedge clk);
      address_mode_bit <= 1'b1;
      hdlc <= 1'b0;
      thr <= 6'h01;
      thr_ld <= 1'b1;
      @(posedge clk);
      thr_ld <= 1'b0;
      rx_byte(8'h3B);
      check(8'(q.size()), 8'h01);
      check(q[0], 8'h3B);
      final_report();
   end
endmodule
